// [alarm_annunciator.sv]
// alarm annunciator top: two lamp channels, two standard-output alarms
// What this block does
// - high absolute alarm when process value at or above alarm value.
// - low absolute alarm when process value at or below alarm value.
// - high offset alarm when value exceeds setpoint by alarm value.
// - low offset alarm when value below setpoint by alarm value.
// - in-band alarm while value within setpoint plus/minus alarm value.
// - out-of-band alarm when value at or beyond setpoint band edges.
// - two lamp channels, each with own comparison type and action.
// - action off never drives lamp or alarm output.
// - normal action lamp follows comparison result directly.
// - latching action lamp stays on until acknowledge keypress.
// - event action ignores comparison, follows recipe events.
// - alarm relay uses same channel settings as its lamp.
// - normal action relay releases as soon as condition clears.
// - latching action relay holds until acknowledge, like the lamp.
// - event action relay mirrors the lamp's recipe-event behaviour.
// - standard-output alarms have same types and actions except event.
// - standard-output and lamp alarms are independent.
// - active setpoint: recipe, then remote, then second, then local.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module alarm_annunciator #(
   parameter int width = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire alarm_pkg::wb_req_t wb_req,
   output alarm_pkg::wb_rsp_t wb_rsp,
   input wire logic pv_upd,
   input wire logic signed [alarm_pkg::data_w-1:0] pv,
   input wire alarm_pkg::sp_src_t sp_src,
   input wire logic ack_key,
   input wire logic [alarm_pkg::n_lamp-1:0] recipe_evt,
   input wire logic [alarm_pkg::n_lamp-1:0] relay_fitted,
   output logic first_alarm_lamp,
   output logic second_alarm_lamp,
   output logic [alarm_pkg::n_lamp-1:0] alarm_relay,
   output logic [alarm_pkg::n_std-1:0] std_alarm_out
);
   import alarm_pkg::*;

   initial
   begin
      if (width != data_w)
      begin
         $error("width must equal package data width");
      end
      if (data_w != 16)
      begin
         $error("read mux pads 16-bit values into a 32-bit word");
      end
      if (n_lamp != 2)
      begin
         $error("two lamp channels map onto the two named lamp pins");
      end
      if (n_std != 2)
      begin
         $error("register map holds exactly two standard-output alarms");
      end
      if (cfg_act_lsb < cfg_cmp_lsb + 3)
      begin
         $error("action field overlaps comparison field");
      end
   end

   chan_cfg_t lamp_cfg_ff [n_lamp];
   chan_cfg_t std_cfg_ff [n_std];
   logic signed [data_w-1:0] lamp_val_ff [n_lamp];
   logic signed [data_w-1:0] std_val_ff [n_std];
   logic signed [data_w-1:0] local_sp_ff;
   logic signed [data_w-1:0] second_sp_ff;
   logic signed [data_w-1:0] active_sp;
   logic ack_prev_ff;
   logic ack_pulse;
   logic ack_ff;
   logic [31:0] nxt_rdat;
   logic [31:0] rdat_ff;
   logic [n_lamp-1:0] lamp_act;
   logic [n_lamp-1:0] lamp_cond;
   logic [n_lamp-1:0] evt_ff;
   logic [n_std-1:0] std_act;
   logic [n_std-1:0] std_cond;
   logic [n_lamp-1:0] lamp_q_ff;
   logic [n_lamp-1:0] relay_q_ff;
   logic [n_std-1:0] std_q_ff;
   logic wr;
   logic req;
   logic [31:0] status_word;

   assign req = wb_req.cyc && wb_req.stb;
   // a write lands at the edge that samples ack high
   assign wr = req && wb_req.we && ack_ff && wb_req.sel[0] && wb_req.sel[1];

   // single-cycle ack: one cycle after the request, dropped next cycle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ack_ff <= 1'b0;
      else
         ack_ff <= req && !ack_ff;
   end

   // lamp channel settings; 16-bit fields need both low byte lanes
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < n_lamp; i++)
         begin
            lamp_cfg_ff[i] <= chan_cfg_t'(cfg_rst[4:0]);
         end
      end
      else if (wr)
      begin
         case (wb_req.adr)
            reg_lamp0_cfg: lamp_cfg_ff[0] <= chan_cfg_t'({
               wb_req.dat[cfg_act_lsb+1:cfg_act_lsb],
               wb_req.dat[cfg_cmp_lsb+2:cfg_cmp_lsb]});
            reg_lamp1_cfg: lamp_cfg_ff[1] <= chan_cfg_t'({
               wb_req.dat[cfg_act_lsb+1:cfg_act_lsb],
               wb_req.dat[cfg_cmp_lsb+2:cfg_cmp_lsb]});
            default: ;
         endcase
      end
   end

   // lamp alarm values
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < n_lamp; i++)
         begin
            lamp_val_ff[i] <= val_rst;
         end
      end
      else if (wr)
      begin
         case (wb_req.adr)
            reg_lamp0_val: lamp_val_ff[0] <= wb_req.dat[data_w-1:0];
            reg_lamp1_val: lamp_val_ff[1] <= wb_req.dat[data_w-1:0];
            default: ;
         endcase
      end
   end

   // local and second setpoints; the other sources arrive as levels
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         local_sp_ff <= val_rst;
         second_sp_ff <= val_rst;
      end
      else if (wr)
      begin
         case (wb_req.adr)
            reg_local_sp: local_sp_ff <= wb_req.dat[data_w-1:0];
            reg_second_sp: second_sp_ff <= wb_req.dat[data_w-1:0];
            default: ;
         endcase
      end
   end

   // standard-output alarm settings kept apart from lamp settings
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < n_std; i++)
         begin
            std_cfg_ff[i] <= chan_cfg_t'(cfg_rst[4:0]);
         end
      end
      else if (wr)
      begin
         case (wb_req.adr)
            reg_std0_cfg: std_cfg_ff[0] <= chan_cfg_t'({
               wb_req.dat[cfg_act_lsb+1:cfg_act_lsb],
               wb_req.dat[cfg_cmp_lsb+2:cfg_cmp_lsb]});
            reg_std1_cfg: std_cfg_ff[1] <= chan_cfg_t'({
               wb_req.dat[cfg_act_lsb+1:cfg_act_lsb],
               wb_req.dat[cfg_cmp_lsb+2:cfg_cmp_lsb]});
            default: ;
         endcase
      end
   end

   // standard-output alarm values
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < n_std; i++)
         begin
            std_val_ff[i] <= val_rst;
         end
      end
      else if (wr)
      begin
         case (wb_req.adr)
            reg_std0_val: std_val_ff[0] <= wb_req.dat[data_w-1:0];
            reg_std1_val: std_val_ff[1] <= wb_req.dat[data_w-1:0];
            default: ;
         endcase
      end
   end

   // active setpoint, highest priority source first
   always_comb
   begin
      if (sp_src.recipe_active)
         active_sp = sp_src.recipe_sp;
      else if (sp_src.remote_en)
         active_sp = sp_src.remote_sp;
      else if (sp_src.second_en)
         active_sp = second_sp_ff;
      else
         active_sp = local_sp_ff;
   end

   // key held for many cycles yields one acknowledge pulse
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ack_prev_ff <= 1'b0;
      else
         ack_prev_ff <= ack_key;
   end
   assign ack_pulse = ack_key && !ack_prev_ff;

   // event levels registered so lamp and relay switch together
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         evt_ff <= '0;
      else
         evt_ff <= recipe_evt;
   end

   for (genvar g = 0; g < n_lamp; g++)
   begin : g_lamp
      alarm_chan #(.width(data_w), .has_event(1'b1)) u_chan (
         .clk(clk),
         .rst_b(rst_b),
         .pv_upd(pv_upd),
         .pv(pv),
         .sp(active_sp),
         .aval(lamp_val_ff[g]),
         .cfg(lamp_cfg_ff[g]),
         .ack(ack_pulse),
         .evt_level(evt_ff[g]),
         .cond(lamp_cond[g]),
         .active(lamp_act[g])
      );
   end

   for (genvar g = 0; g < n_std; g++)
   begin : g_std
      // event action unavailable here: treated as off
      alarm_chan #(.width(data_w), .has_event(1'b0)) u_chan (
         .clk(clk),
         .rst_b(rst_b),
         .pv_upd(pv_upd),
         .pv(pv),
         .sp(active_sp),
         .aval(std_val_ff[g]),
         .cfg(std_cfg_ff[g]),
         .ack(ack_pulse),
         .evt_level(1'b0),
         .cond(std_cond[g]),
         .active(std_act[g])
      );
   end

   // outputs from flip-flops; relay tracks the same channel state as lamp
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         lamp_q_ff <= '0;
      else
         lamp_q_ff <= lamp_act;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         relay_q_ff <= '0;
      // relay shares the lamp's channel state
      else
         relay_q_ff <= lamp_act & relay_fitted;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         std_q_ff <= '0;
      else
         std_q_ff <= std_act;
   end

   assign first_alarm_lamp = lamp_q_ff[0];
   assign second_alarm_lamp = lamp_q_ff[1];
   assign alarm_relay = relay_q_ff;
   assign std_alarm_out = std_q_ff;

   // status: lamps, relays, standard outputs, then the held conditions
   assign status_word = {22'h0, std_cond, lamp_cond, std_q_ff, relay_q_ff,
      lamp_q_ff};

   always_comb
   begin
      nxt_rdat = 32'h0000_0000;
      case (wb_req.adr)
         reg_lamp0_cfg: nxt_rdat = {26'h0, lamp_cfg_ff[0].act, 1'b0,
            lamp_cfg_ff[0].cmp};
         reg_lamp0_val: nxt_rdat = {16'h0, lamp_val_ff[0]};
         reg_lamp1_cfg: nxt_rdat = {26'h0, lamp_cfg_ff[1].act, 1'b0,
            lamp_cfg_ff[1].cmp};
         reg_lamp1_val: nxt_rdat = {16'h0, lamp_val_ff[1]};
         reg_std0_cfg: nxt_rdat = {26'h0, std_cfg_ff[0].act, 1'b0,
            std_cfg_ff[0].cmp};
         reg_std0_val: nxt_rdat = {16'h0, std_val_ff[0]};
         reg_std1_cfg: nxt_rdat = {26'h0, std_cfg_ff[1].act, 1'b0,
            std_cfg_ff[1].cmp};
         reg_std1_val: nxt_rdat = {16'h0, std_val_ff[1]};
         reg_local_sp: nxt_rdat = {16'h0, local_sp_ff};
         reg_second_sp: nxt_rdat = {16'h0, second_sp_ff};
         reg_status: nxt_rdat = status_word;
         reg_active_sp: nxt_rdat = {16'h0, active_sp};
         default: nxt_rdat = 32'h0000_0000;
      endcase
   end

   // read data captured as the request is seen; it stands with ack
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdat_ff <= 32'h0000_0000;
      else if (req && !ack_ff)
         rdat_ff <= nxt_rdat;
   end

   assign wb_rsp.ack = ack_ff;
   assign wb_rsp.dat = rdat_ff;
endmodule
`default_nettype wire

// [alarm_pkg.sv]
// shared constants, types and register map for the alarm annunciator
package alarm_pkg;
   localparam int data_w = 16;
   localparam int adr_w = 8;
   localparam int n_lamp = 2;
   localparam int n_std = 2;

   // comparison type codes (3-bit field)
   localparam logic [2:0] cmp_proc_hi = 3'h0;
   localparam logic [2:0] cmp_proc_lo = 3'h1;
   localparam logic [2:0] cmp_dev_hi = 3'h2;
   localparam logic [2:0] cmp_dev_lo = 3'h3;
   localparam logic [2:0] cmp_in_band = 3'h4;
   localparam logic [2:0] cmp_out_band = 3'h5;

   // action codes (2-bit field)
   localparam logic [1:0] act_off = 2'h0;
   localparam logic [1:0] act_normal = 2'h1;
   localparam logic [1:0] act_latch = 2'h2;
   localparam logic [1:0] act_event = 2'h3;

   // channel config word layout
   localparam int cfg_cmp_lsb = 0;
   localparam int cfg_act_lsb = 4;

   // register byte addresses
   localparam logic [adr_w-1:0] reg_lamp0_cfg = 8'h00;
   localparam logic [adr_w-1:0] reg_lamp0_val = 8'h04;
   localparam logic [adr_w-1:0] reg_lamp1_cfg = 8'h08;
   localparam logic [adr_w-1:0] reg_lamp1_val = 8'h0c;
   localparam logic [adr_w-1:0] reg_std0_cfg = 8'h10;
   localparam logic [adr_w-1:0] reg_std0_val = 8'h14;
   localparam logic [adr_w-1:0] reg_std1_cfg = 8'h18;
   localparam logic [adr_w-1:0] reg_std1_val = 8'h1c;
   localparam logic [adr_w-1:0] reg_local_sp = 8'h20;
   localparam logic [adr_w-1:0] reg_second_sp = 8'h24;
   localparam logic [adr_w-1:0] reg_status = 8'h28;
   localparam logic [adr_w-1:0] reg_active_sp = 8'h2c;

   // reset values
   localparam logic [7:0] cfg_rst = 8'h00;
   localparam logic [data_w-1:0] val_rst = 16'h0000;

   typedef struct packed {
      logic [1:0] act;
      logic [2:0] cmp;
   } chan_cfg_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [adr_w-1:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // setpoint sources, in priority order
   typedef struct packed {
      logic recipe_active;
      logic [data_w-1:0] recipe_sp;
      logic remote_en;
      logic [data_w-1:0] remote_sp;
      logic second_en;
   } sp_src_t;
endpackage

// [alarm_chan.sv]
// one alarm channel: comparison plus action (off/normal/latch/event)
`timescale 1ns/100ps
`default_nettype none
module alarm_chan #(
   parameter int width = 16,
   parameter bit has_event = 1'b1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pv_upd,
   input wire logic signed [width-1:0] pv,
   input wire logic signed [width-1:0] sp,
   input wire logic signed [width-1:0] aval,
   input wire alarm_pkg::chan_cfg_t cfg,
   input wire logic ack,
   input wire logic evt_level,
   output logic cond,
   output logic active
);
   import alarm_pkg::*;

   initial
   begin
      if (width < 2)
      begin
         $error("alarm_chan width too small");
      end
   end

   logic cond_ff;
   logic nxt_cond;
   logic latch_ff;
   logic signed [width:0] pv_x;
   logic signed [width:0] hi_x;
   logic signed [width:0] lo_x;
   logic signed [width:0] av_x;

   // one extra bit so sp +/- value never wraps
   assign pv_x = {pv[width-1], pv};
   assign av_x = {aval[width-1], aval};
   assign hi_x = {sp[width-1], sp} + av_x;
   assign lo_x = {sp[width-1], sp} - av_x;

   always_comb
   begin
      case (cfg.cmp)
         cmp_proc_hi: nxt_cond = pv >= aval;
         cmp_proc_lo: nxt_cond = pv <= aval;
         cmp_dev_hi: nxt_cond = pv_x >= hi_x;
         cmp_dev_lo: nxt_cond = pv_x <= lo_x;
         cmp_in_band: nxt_cond = (pv_x >= lo_x) && (pv_x <= hi_x);
         cmp_out_band: nxt_cond = (pv_x >= hi_x) || (pv_x <= lo_x);
         default: nxt_cond = 1'b0;
      endcase
   end

   // comparison is held between process-value updates
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cond_ff <= 1'b0;
      else if (pv_upd)
         cond_ff <= nxt_cond;
   end

   // latch: set wins over acknowledge; ack clears only if condition gone
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         latch_ff <= 1'b0;
      else if (cfg.act != act_latch)
         latch_ff <= 1'b0;
      else if (cond_ff)
         latch_ff <= 1'b1;
      else if (ack)
         latch_ff <= 1'b0;
   end

   assign cond = cond_ff;

   always_comb
   begin
      case (cfg.act)
         act_off: active = 1'b0;
         act_normal: active = cond_ff;
         act_latch: active = latch_ff;
         act_event: active = has_event ? evt_level : 1'b0;
         default: active = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// [alarm_annunciator_monitor.sv]
// checker for the alarm annunciator ports
`timescale 1ns/100ps
`default_nettype none
module alarm_monitor #(
   parameter int width = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire alarm_pkg::wb_req_t wb_req,
   input wire alarm_pkg::wb_rsp_t wb_rsp,
   input wire logic pv_upd,
   input wire logic [alarm_pkg::n_lamp-1:0] relay_fitted,
   input wire logic first_alarm_lamp,
   input wire logic second_alarm_lamp,
   input wire logic [alarm_pkg::n_lamp-1:0] alarm_relay
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_ack_one;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("no ack one cycle after request");
   property p_ack_pulse;
      wb_rsp.ack |=> !wb_rsp.ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_no_req;
      !(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack;
   endproperty
   a_no_req: assert property (p_no_req)
      else $error("ack without request");
   property p_upper;
      wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper read bits not zero");
   property p_start_off;
      $rose(rst_b) |-> !first_alarm_lamp && !second_alarm_lamp;
   endproperty
   a_start_off: assert property (p_start_off)
      else $error("lamp lit after reset");
   property p_unfit;
      !relay_fitted[0] && $past(!relay_fitted[0]) |-> !alarm_relay[0];
   endproperty
   a_unfit: assert property (p_unfit)
      else $error("unfitted relay driven");
   property p_relay0;
      relay_fitted[0] && $past(relay_fitted[0])
         |-> alarm_relay[0] == first_alarm_lamp;
   endproperty
   a_relay0: assert property (p_relay0)
      else $error("relay 0 differs from lamp");
   property p_relay1;
      relay_fitted[1] && $past(relay_fitted[1])
         |-> alarm_relay[1] == second_alarm_lamp;
   endproperty
   a_relay1: assert property (p_relay1)
      else $error("relay 1 differs from lamp");
   c_lamp0: cover property ($rose(first_alarm_lamp));
   c_lamp1: cover property ($fell(second_alarm_lamp));
   c_upd: cover property (pv_upd ##2 first_alarm_lamp);
endmodule
bind alarm_annunciator alarm_monitor #(.width(width)) mon (.clk(clk),
   .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp), .pv_upd(pv_upd),
   .relay_fitted(relay_fitted), .first_alarm_lamp(first_alarm_lamp),
   .second_alarm_lamp(second_alarm_lamp), .alarm_relay(alarm_relay));
`default_nettype wire

// [panel_model.sv]
// operator panel: acknowledge key giving one pulse per press
`timescale 1ns/100ps
`default_nettype none
module panel_model (
   input wire logic clk,
   input wire logic press,
   output logic ack_key
);
   logic held_ff;
   initial ack_key = 1'b0;
   initial held_ff = 1'b0;
   // one pulse per press however long the key is held
   always @(posedge clk)
   begin
      held_ff <= press;
      ack_key <= press && !held_ff;
   end
endmodule
`default_nettype wire

// [alarm_annunciator_bench.sv]
// self-checking bench for the alarm annunciator
`timescale 1ns/100ps
`default_nettype none
module alarm_annunciator_bench;
   import alarm_pkg::*;
   logic clk = 0, rst_b = 0, pv_upd = 0, press = 0, ack_key;
   logic [15:0] pv = 0;
   logic [1:0] evt = 0, fit = 0, lamps, relay, std;
   wb_req_t req = '0;
   wb_rsp_t rsp;
   sp_src_t src = '0;
   logic [31:0] q;
   int num_errors = 0, n_compared = 0;
   always #20 clk = ~clk;
   alarm_annunciator dut (.clk(clk), .rst_b(rst_b), .wb_req(req),
      .wb_rsp(rsp), .pv_upd(pv_upd), .pv(pv), .sp_src(src),
      .ack_key(ack_key), .recipe_evt(evt), .relay_fitted(fit),
      .first_alarm_lamp(lamps[0]), .second_alarm_lamp(lamps[1]),
      .alarm_relay(relay), .std_alarm_out(std));
   panel_model panel (.clk(clk), .press(press), .ack_key(ack_key));
   task automatic end_sim;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, w, 4'hf, a, d};
      do
      begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      if (n == 20)
      begin
         num_errors++;
         $display("CHECK FAILED %0t no bus ack", $time);
         end_sim();
      end
      else
      begin
         q = rsp.dat;
         req.cyc <= 1'b0;
         req.stb <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic upd(input int v);
      pv <= 16'(v);
      pv_upd <= 1'b1;
      @(posedge clk);
      pv_upd <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   function automatic logic ex(int c, int p, int s, int v);
      case (c)
         0: return p >= v;
         1: return p <= v;
         2: return p >= s + v;
         3: return p <= s - v;
         4: return p >= s - v && p <= s + v;
         default: return p <= s - v || p >= s + v;
      endcase
   endfunction
   int pvs[6] = '{89, 90, 95, 105, 110, 111};
   int v;
   logic e;
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(0, reg_lamp0_cfg, 0);
      chk(q, 0);
      bus(0, 8'h40, 0);
      chk(q, 0);
      fit <= 2'b11;
      bus(1, reg_local_sp, 100);
      bus(1, reg_second_sp, 200);
      for (int c = 0; c < 6; c++)
      begin
         v = (c < 2) ? 105 : 10;
         bus(1, reg_lamp0_val, v);
         bus(1, reg_lamp0_cfg, {26'h0, act_normal, 1'b0, 3'(c)});
         foreach (pvs[i])
         begin
            upd(pvs[i]);
            e = ex(c, pvs[i], 100, v);
            chk({lamps[0], relay[0]}, {e, e});
         end
      end
      upd(-200);
      chk(lamps[0], 1'b1);
      bus(1, reg_lamp0_cfg, {act_off, 1'b0, cmp_proc_lo});
      upd(-200);
      chk({lamps[0], relay[0]}, 0);
      bus(1, reg_lamp0_cfg, {act_normal, 1'b0, 3'h6});
      upd(-200);
      chk(lamps[0], 1'b0);
      bus(1, reg_lamp0_cfg, {act_event, 1'b0, cmp_proc_lo});
      evt <= 2'b01;
      upd(-200);
      chk({lamps[0], relay[0]}, 2'b11);
      evt <= 2'b00;
      upd(-200);
      chk(lamps[0], 1'b0);
      bus(1, reg_lamp1_val, 50);
      bus(1, reg_lamp1_cfg, {act_latch, 1'b0, cmp_proc_hi});
      bus(1, reg_std0_val, 50);
      bus(1, reg_std0_cfg, {act_event, 1'b0, cmp_proc_hi});
      upd(60);
      press <= 1'b1;
      repeat (4) @(posedge clk);
      press <= 1'b0;
      chk({std, lamps[1], relay[1]}, 4'b0011);
      upd(40);
      chk({lamps[1], relay[1]}, 2'b11);
      fit <= 2'b01;
      repeat (2) @(posedge clk);
      chk({lamps[1], relay[1]}, 2'b10);
      fit <= 2'b11;
      @(posedge clk);
      bus(1, reg_std0_cfg, {act_normal, 1'b0, cmp_proc_hi});
      press <= 1'b1;
      upd(60);
      press <= 1'b0;
      chk({std, lamps[1]}, 3'b011);
      upd(40);
      chk({std, lamps[1]}, 3'b001);
      press <= 1'b1;
      repeat (4) @(posedge clk);
      press <= 1'b0;
      chk({lamps[1], relay[1]}, 0);
      src <= '{1'b0, 16'h0, 1'b0, 16'h0, 1'b1};
      @(posedge clk);
      bus(0, reg_active_sp, 0);
      chk(q, 200);
      src <= '{1'b0, 16'h0, 1'b1, 16'h012c, 1'b1};
      @(posedge clk);
      bus(0, reg_active_sp, 0);
      chk(q, 300);
      src <= '{1'b1, 16'h0190, 1'b1, 16'h012c, 1'b1};
      @(posedge clk);
      bus(0, reg_active_sp, 0);
      chk(q, 400);
      end_sim();
   end
endmodule
`default_nettype wire
